//--- pcd_bank_regs.svh
/*
 * Register indices, field positions, reset values and bus response codes
 * of the transceiver management bank.
 * Assumes that every file including it needs them at the widths given here.
 */
`ifndef PCD_BANK_REGS_SVH
`define PCD_BANK_REGS_SVH

// Register indices; the byte address on the bus is four times the index.
`define PCD_IDX_EVENT       5'h1b
`define PCD_IDX_DIAG        5'h1d
`define PCD_IDX_CTRL1       5'h1e
`define PCD_IDX_CTRL2       5'h1f

// Field positions inside the 16-bit registers.
`define PCD_EVT_EN_LSB      4'h8
`define PCD_DIAG_START_BIT  4'hf
`define PCD_DIAG_RES_LSB    4'hd
`define PCD_LED_MODE_LSB    4'he
`define PCD_POLARITY_BIT    4'hd
`define PCD_FAR_END_BIT     4'hc
`define PCD_CROSSED_BIT     4'hb
`define PCD_INT_LEVEL_BIT   4'h9

// Reset values.
`define PCD_EVT_EN_RST      8'h00
`define PCD_FLAGS_RST       8'h00
`define PCD_LED_MODE_RST    2'h0
`define PCD_INT_LEVEL_RST   1'h0
`define PCD_DIAG_RES_RST    2'h0
`define PCD_DIAG_DIST_RST   9'h000

// Bus response codes.
`define PCD_RESP_OKAY       2'h0
`define PCD_RESP_SLVERR     2'h2

`endif

//--- pcd_pkg.sv
/*
 * Types shared by the transceiver management bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package pcd_pkg;

    // One pulse per event; member order matches the flag bit order, jabber on top.
    typedef struct packed {
        logic jabber;
        logic rx_error;
        logic page_rx;
        logic par_fault;
        logic lp_ack;
        logic link_down;
        logic rem_fault;
        logic link_up;
    } pcd_events_t;

    // End of a cable diagnostic run, with its outcome.
    typedef struct packed {
        logic       done;
        logic [1:0] result;
        logic [8:0] distance;
    } pcd_diag_t;

    // Line state reported by the analog side.
    typedef struct packed {
        logic polarity_rev;
        logic far_end_fault;
        logic crossed_pair_mode;
        logic link_up;
        logic activity;
        logic speed_100;
    } pcd_line_t;

    typedef enum logic [1:0] {
        PCD_LED_SPEED_LINKACT = 2'h0,
        PCD_LED_ACT_LINK      = 2'h1
    } pcd_led_mode_t;

    typedef enum logic [1:0] {
        PCD_DIAG_NORMAL = 2'h0,
        PCD_DIAG_OPEN   = 2'h1,
        PCD_DIAG_SHORT  = 2'h2,
        PCD_DIAG_FAILED = 2'h3
    } pcd_diag_code_t;

endpackage

//--- pcd_flags.sv
/*
 * Eight sticky event flags that clear together on a read.
 * Assumes event pulses and the clear strobe are synchronous to clk.
 */
`timescale 1ns/1ps
`include "pcd_bank_regs.svh"

module pcd_flags (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic [7:0] set,
    input  wire logic       clr,
    output logic [7:0]      flags
);
    import pcd_pkg::*;

    logic [7:0] next_flags;

    // A read clears all flags, but an event in the same cycle survives it.
    assign next_flags = (clr ? 8'h00 : flags) | set;

    // Flags hold until the next read of their register.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            flags <= `PCD_FLAGS_RST;
        end else if (ce) begin
            flags <= next_flags;
        end
    end

    // Every event raises its flag at the next edge, clear or not.
    a_set_wins: assert property (@(posedge clk) disable iff (!nrst)
        ce |=> ((flags & $past(set)) == $past(set)))
        else $error("event lost against a read clear");

    // After a clear only the events of that cycle remain.
    a_read_clears: assert property (@(posedge clk) disable iff (!nrst)
        (ce && clr) |=> ((flags & ~$past(set)) == 8'h00))
        else $error("flag survived a read clear");

    // Without a clear no flag drops.
    a_flag_sticky: assert property (@(posedge clk) disable iff (!nrst)
        (ce && !clr) |=> ((flags & $past(flags)) == $past(flags)))
        else $error("flag dropped without a read");

    c_event_during_clear: cover property (@(posedge clk) disable iff (!nrst)
        ce && clr && (set != 8'h00));

endmodule

//--- pcd_bank.sv
/*
 * Management register bank: event enables and flags, cable diagnostic
 * control and status, indicator mode and line status, interrupt pin.
 * Assumes an AXI4-Lite master on CLK and event pulses synchronous to CLK.
 */
//
// Overview of operation
// - Link-up enable bit gates the link-up flag onto the interrupt pin.
// - Jabber flag sets on jabber and clears when its register is read.
// - Receive-error flag sets on a receive error and clears on read.
// - Page-received flag sets on a received page and clears on read.
// - Parallel-detect-fault flag sets on that fault and clears on read.
// - Partner-acknowledge flag sets on that event; otherwise zero; resets to zero.
// - Link-down flag sets when the link drops; otherwise zero; resets to zero.
// - Remote-fault flag sets on a partner remote fault and clears on read.
// - Link-up flag sets when link comes up and clears on read.
// - Writing one starts a diagnostic run; the bit clears when it ends.
// - Two-bit result: normal, open, short, failed; resets to normal.
// - Nine-bit fault distance, about 0.4 m per unit, resets to zero.
// - Two-bit indicator mode picks indicator use; codes two and three reserved.
// - Read-only bit shows reversed receive polarity.
// - Read-only far-end fault bit, zero at reset, fiber variant only.
// - Read-only bit shows straight (0) or crossed (1) pair assignment.
// - Interrupt level bit selects active-high (1) or active-low (0) pin.
`timescale 1ns/1ps
`include "pcd_bank_regs.svh"

module pcd_bank (
    input  wire logic                CLK,
    input  wire logic                NRST,
    input  wire logic                CE,
    input  wire logic [7:0]          S_AXI_AWADDR,
    input  wire logic                S_AXI_AWVALID,
    output logic                     S_AXI_AWREADY,
    input  wire logic [31:0]         S_AXI_WDATA,
    input  wire logic [3:0]          S_AXI_WSTRB,
    input  wire logic                S_AXI_WVALID,
    output logic                     S_AXI_WREADY,
    output logic [1:0]               S_AXI_BRESP,
    output logic                     S_AXI_BVALID,
    input  wire logic                S_AXI_BREADY,
    input  wire logic [7:0]          S_AXI_ARADDR,
    input  wire logic                S_AXI_ARVALID,
    output logic                     S_AXI_ARREADY,
    output logic [31:0]              S_AXI_RDATA,
    output logic [1:0]               S_AXI_RRESP,
    output logic                     S_AXI_RVALID,
    input  wire logic                S_AXI_RREADY,
    input  wire pcd_pkg::pcd_events_t EVENTS,
    input  wire pcd_pkg::pcd_diag_t   DIAG_RES,
    input  wire pcd_pkg::pcd_line_t   LINE,
    output logic                     DIAG_START,
    output logic [1:0]               LED_MODE,
    output logic                     INDICATOR_FIRST,
    output logic                     INDICATOR_SECOND,
    output logic                     INT_PIN
);
    import pcd_pkg::*;

    // Compares a byte address with the word of a register index.
    function automatic logic reg_hit(input logic [7:0] addr, input logic [4:0] idx);
        reg_hit = (addr == {1'b0, idx, 2'b00});
    endfunction

    // True for any implemented register.
    function automatic logic reg_mapped(input logic [7:0] addr);
        reg_mapped = reg_hit(addr, `PCD_IDX_EVENT) || reg_hit(addr, `PCD_IDX_DIAG) ||
                     reg_hit(addr, `PCD_IDX_CTRL1) || reg_hit(addr, `PCD_IDX_CTRL2);
    endfunction

    logic        aw_held;
    logic [7:0]  aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  evt_en;
    logic [7:0]  flags;
    logic        diag_start;
    logic [1:0]  diag_code;
    logic [8:0]  diag_dist;
    logic [1:0]  led_mode;
    logic        int_level;
    logic        int_pin;
    logic        ind_first;
    logic        ind_second;

    // Write channel handshakes; address and data are taken in either order.
    wire         aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
    wire         w_fire  = S_AXI_WVALID && S_AXI_WREADY;
    wire [7:0]   wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
    wire [31:0]  wr_data = w_held ? w_data : S_AXI_WDATA;
    wire [3:0]   wr_strb = w_held ? w_strb : S_AXI_WSTRB;
    wire         wr_go   = (aw_held || aw_fire) && (w_held || w_fire);

    assign S_AXI_AWREADY = !aw_held && !bvalid;
    assign S_AXI_WREADY  = !w_held && !bvalid;
    assign S_AXI_BVALID  = bvalid;
    assign S_AXI_BRESP   = bresp;

    // Register write strobes; every writable field sits in byte lane one.
    wire wr_event = wr_go && reg_hit(wr_addr, `PCD_IDX_EVENT) && wr_strb[1];
    wire wr_diag  = wr_go && reg_hit(wr_addr, `PCD_IDX_DIAG) && wr_strb[1] &&
                    wr_data[`PCD_DIAG_START_BIT];
    wire wr_ctrl1 = wr_go && reg_hit(wr_addr, `PCD_IDX_CTRL1) && wr_strb[1];
    wire wr_ctrl2 = wr_go && reg_hit(wr_addr, `PCD_IDX_CTRL2) && wr_strb[1];

    // Write channel state: hold address or data until the partner arrives.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            aw_held <= 1'h0;
            aw_addr <= 8'h00;
            w_held  <= 1'h0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            bvalid  <= 1'h0;
            bresp   <= `PCD_RESP_OKAY;
        end else if (CE) begin
            if (bvalid && S_AXI_BREADY) begin
                bvalid <= 1'h0;
            end
            if (wr_go) begin
                aw_held <= 1'h0;
                w_held  <= 1'h0;
                bvalid  <= 1'h1;
                bresp   <= reg_mapped(wr_addr) ? `PCD_RESP_OKAY : `PCD_RESP_SLVERR;
            end else begin
                if (aw_fire) begin
                    aw_held <= 1'h1;
                    aw_addr <= S_AXI_AWADDR;
                end
                if (w_fire) begin
                    w_held <= 1'h1;
                    w_data <= S_AXI_WDATA;
                    w_strb <= S_AXI_WSTRB;
                end
            end
        end
    end

    // Read channel: one read at a time, answered the cycle after the address.
    wire ar_fire  = S_AXI_ARVALID && S_AXI_ARREADY;
    wire rd_clear = CE && ar_fire && reg_hit(S_AXI_ARADDR, `PCD_IDX_EVENT);

    assign S_AXI_ARREADY = !rvalid;
    assign S_AXI_RVALID  = rvalid;
    assign S_AXI_RDATA   = rdata;
    assign S_AXI_RRESP   = rresp;

    // Read words of the four registers; reserved bits read zero.
    wire [15:0] word_event = {evt_en, flags};
    wire [15:0] word_diag  = {diag_start, diag_code, 4'h0, diag_dist};
    wire [15:0] word_ctrl1 = {led_mode, LINE.polarity_rev, LINE.far_end_fault,
                              LINE.crossed_pair_mode, 11'h000};
    wire [15:0] word_ctrl2 = {6'h00, int_level, 9'h000};
    wire [15:0] rd_word    = reg_hit(S_AXI_ARADDR, `PCD_IDX_EVENT) ? word_event :
                             reg_hit(S_AXI_ARADDR, `PCD_IDX_DIAG)  ? word_diag  :
                             reg_hit(S_AXI_ARADDR, `PCD_IDX_CTRL1) ? word_ctrl1 :
                             reg_hit(S_AXI_ARADDR, `PCD_IDX_CTRL2) ? word_ctrl2 : 16'h0000;

    // Read data is captured at the address handshake, before any clear acts.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rvalid <= 1'h0;
            rdata  <= 32'h0000_0000;
            rresp  <= `PCD_RESP_OKAY;
        end else if (CE) begin
            if (ar_fire) begin
                rvalid <= 1'h1;
                rdata  <= {16'h0000, rd_word};
                rresp  <= reg_mapped(S_AXI_ARADDR) ? `PCD_RESP_OKAY : `PCD_RESP_SLVERR;
            end else if (rvalid && S_AXI_RREADY) begin
                rvalid <= 1'h0;
            end
        end
    end

    // Sticky event flags, cleared together by a read of their register.
    pcd_flags u_flags (
        .clk   (CLK),
        .nrst  (NRST),
        .ce    (CE),
        .set   (EVENTS),
        .clr   (rd_clear),
        .flags (flags)
    );

    // A write of one starts a run; the end of the run clears the bit.
    wire next_diag_start = wr_diag ? 1'h1 : (DIAG_RES.done ? 1'h0 : diag_start);
    wire diag_finish     = DIAG_RES.done && diag_start;

    // Control fields and diagnostic outcome.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            evt_en     <= `PCD_EVT_EN_RST;
            diag_start <= 1'h0;
            diag_code  <= `PCD_DIAG_RES_RST;
            diag_dist  <= `PCD_DIAG_DIST_RST;
            led_mode   <= `PCD_LED_MODE_RST;
            int_level  <= `PCD_INT_LEVEL_RST;
        end else if (CE) begin
            if (wr_event) begin
                evt_en <= wr_data[`PCD_EVT_EN_LSB +: 8];
            end
            diag_start <= next_diag_start;
            if (diag_finish) begin
                diag_code <= DIAG_RES.result;
                diag_dist <= DIAG_RES.distance;
            end
            if (wr_ctrl1) begin
                led_mode <= wr_data[`PCD_LED_MODE_LSB +: 2];
            end
            if (wr_ctrl2) begin
                int_level <= wr_data[`PCD_INT_LEVEL_BIT];
            end
        end
    end

    // Indicator routing by mode; reserved modes leave both dark.
    wire ind_mode0 = (led_mode == PCD_LED_SPEED_LINKACT);
    wire ind_mode1 = (led_mode == PCD_LED_ACT_LINK);
    wire next_ind_first  = ind_mode0 ? (LINE.link_up && !LINE.activity) :
                           ind_mode1 ? LINE.link_up : 1'h0;
    wire next_ind_second = ind_mode0 ? LINE.speed_100 :
                           ind_mode1 ? LINE.activity : 1'h0;

    // Interrupt is active while any enabled flag stands, at the chosen level.
    wire int_active   = |(flags & evt_en);
    wire next_int_pin = int_level ? int_active : !int_active;

    // Registered pin outputs.
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            int_pin    <= 1'h1;
            ind_first  <= 1'h0;
            ind_second <= 1'h0;
        end else if (CE) begin
            int_pin    <= next_int_pin;
            ind_first  <= next_ind_first;
            ind_second <= next_ind_second;
        end
    end

    assign DIAG_START       = diag_start;
    assign LED_MODE         = led_mode;
    assign INDICATOR_FIRST  = ind_first;
    assign INDICATOR_SECOND = ind_second;
    assign INT_PIN          = int_pin;

    // A lone link-up flag with its enable clear keeps the pin idle.
    a_link_up_mask: assert property (@(posedge CLK) disable iff (!NRST)
        (CE && flags == 8'h01 && !evt_en[0]) |=> (INT_PIN == !$past(int_level)))
        else $error("masked link-up flag drove the interrupt");

    // An enabled flag drives the pin to the selected active level.
    a_int_level: assert property (@(posedge CLK) disable iff (!NRST)
        (CE && int_active) |=> (INT_PIN == $past(int_level)))
        else $error("interrupt pin not at its active level");

    // With no enabled flag the pin is idle.
    a_int_release: assert property (@(posedge CLK) disable iff (!NRST)
        (CE && (flags & evt_en) == 8'h00) |=> (INT_PIN != $past(int_level)))
        else $error("interrupt pin active with no enabled flag");

    // A start write raises the bit at the next edge.
    a_diag_start: assert property (@(posedge CLK) disable iff (!NRST)
        (CE && wr_diag) |=> DIAG_START)
        else $error("diagnostic start bit not set by write");

    // End of a run clears the bit and loads the outcome.
    a_diag_finish: assert property (@(posedge CLK) disable iff (!NRST)
        (CE && diag_finish && !wr_diag) |=>
            (!DIAG_START && diag_code == $past(DIAG_RES.result) &&
             diag_dist == $past(DIAG_RES.distance)))
        else $error("diagnostic run end not handled");

    // The outcome only changes at the end of a run.
    a_diag_hold: assert property (@(posedge CLK) disable iff (!NRST)
        (CE && !diag_finish) |=> ($stable(diag_code) && $stable(diag_dist)))
        else $error("diagnostic outcome changed outside a run end");

    // A read of the flag register returns the flags as they stood.
    a_read_flags: assert property (@(posedge CLK) disable iff (!NRST)
        rd_clear |=> (S_AXI_RVALID && S_AXI_RDATA[7:0] == $past(flags)))
        else $error("flag read returned wrong value");

    // Line status bits are reported unchanged.
    a_line_status: assert property (@(posedge CLK) disable iff (!NRST)
        (CE && ar_fire && reg_hit(S_AXI_ARADDR, `PCD_IDX_CTRL1)) |=>
            (S_AXI_RDATA[13:11] == $past({LINE.polarity_rev, LINE.far_end_fault,
                                          LINE.crossed_pair_mode})))
        else $error("line status misreported");

    // Reserved indicator modes keep both indicators dark.
    a_led_reserved: assert property (@(posedge CLK) disable iff (!NRST)
        (CE && led_mode[1]) |=> (!INDICATOR_FIRST && !INDICATOR_SECOND))
        else $error("indicator lit in a reserved mode");

    // Every completed write is answered at the next edge.
    a_write_answer: assert property (@(posedge CLK) disable iff (!NRST)
        (CE && wr_go) |=> S_AXI_BVALID)
        else $error("write not answered");

    c_diag_run: cover property (@(posedge CLK) disable iff (!NRST)
        wr_diag ##[1:50] diag_finish);
    c_int_active: cover property (@(posedge CLK) disable iff (!NRST)
        int_active && int_level);
    c_flag_read: cover property (@(posedge CLK) disable iff (!NRST)
        rd_clear && flags != 8'h00);
    c_split_write: cover property (@(posedge CLK) disable iff (!NRST)
        w_held && !aw_held ##1 wr_go);

endmodule

//--- pcd_mac_model.sv
/*
 * AXI4-Lite master model of the management controller.
 * Assumes slave readies settle before the falling edge of clk.
 */
`timescale 1ns/1ps

module pcd_mac_model (
    input  wire logic        clk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // Idle levels; the answer readies stay high for good.
    initial begin
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b1;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b1;
    end

    // One write offered just after the next rising edge; each half drops at its own
    // handshake edge, released lines invert.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta;
        logic tw;
        logic tb;
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            wstrb <= 4'hf;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            tb = 1'b0;
            while (!tb) begin
                @(negedge clk);
                ta = awvalid && awready;
                tw = wvalid && wready;
                tb = bvalid;
                r = bresp;
                @(posedge clk);
                if (ta) begin
                    awvalid <= 1'b0;
                    awaddr <= ~a;
                end
                if (tw) begin
                    wvalid <= 1'b0;
                    wdata <= ~d;
                end
            end
        end
    endtask

    // One read offered just after the next rising edge; data and response are those
    // standing at the edge that ends it.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic tr;
        logic tv;
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            tv = 1'b0;
            while (!tv) begin
                @(negedge clk);
                tr = arvalid && arready;
                tv = rvalid;
                d = rdata;
                r = rresp;
                @(posedge clk);
                if (tr) begin
                    arvalid <= 1'b0;
                    araddr <= ~a;
                end
            end
        end
    endtask
endmodule

//--- tb_pcd_bank.sv
/*
 * Self-checking bench of the management register bank.
 * Assumes the bank answers AXI4-Lite one cycle after a request.
 */
`timescale 1ns/1ps
`include "pcd_bank_regs.svh"

module tb_pcd_bank;
    import pcd_pkg::*;
    typedef struct packed { logic [7:0] ev; logic [31:0] rd; } pcd_tb_row_t;
    logic        clk, nrst, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, diag_start, ind_first, ind_second;
    logic        int_pin;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, prev, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, led_mode, r;
    pcd_events_t events;
    pcd_diag_t   diag;
    pcd_line_t   line;
    int          fail_count, checks_done;
    pcd_tb_row_t rows [9] = '{'{8'h01, 32'h01}, '{8'h02, 32'h02}, '{8'h04, 32'h04},
        '{8'h08, 32'h08}, '{8'h10, 32'h10}, '{8'h20, 32'h20}, '{8'h40, 32'h40},
        '{8'h80, 32'h80}, '{8'ha5, 32'ha5}};

    pcd_bank pcd_bank_inst (.CLK(clk), .NRST(nrst), .CE(ce), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .EVENTS(events), .DIAG_RES(diag), .LINE(line),
        .DIAG_START(diag_start), .LED_MODE(led_mode), .INDICATOR_FIRST(ind_first),
        .INDICATOR_SECOND(ind_second), .INT_PIN(int_pin));

    pcd_mac_model pcd_mac_model_inst (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));

    // The 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Comparison of register words and responses.
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t reg got %h want %h", $time, got, exp);
        end
    endtask

    // Comparison of single output pins.
    task automatic chk_pin(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t pin got %b want %b", $time, got, exp);
        end
    endtask

    // Bus helpers that compare what comes back.
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        pcd_mac_model_inst.rd(a, d, r);
        chk_reg(d, e);
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] v);
        pcd_mac_model_inst.wr(a, v, r);
        chk_reg({30'h0, r}, {30'h0, `PCD_RESP_OKAY});
    endtask

    task automatic pulse(input logic [7:0] ev);
        events <= ev;
        @(posedge clk);
        events <= 8'h00;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of under two thousand cycles.
    initial begin
        #50000;
        fail_count++;
        stop_test;
    end

    // Main sequence.
    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        events = 8'h00;
        diag = '0;
        line = '0;
        fail_count = 0;
        checks_done = 0;
        prev = 32'h0;
        settle(20);
        chk_pin(int_pin, 1'b1);
        @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdc(8'h6c, 32'h0);
        rdc(8'h74, 32'h0);
        rdc(8'h78, 32'h0);
        rdc(8'h7c, 32'h0);
        foreach (rows[i]) begin
            pulse(rows[i].ev);
            rdc(8'h6c, rows[i].rd);
            rdc(8'h6c, 32'h0);
        end
        // Flags refuse writes; only the link-up event is enabled.
        wrc(8'h6c, 32'h01ff);
        pulse(8'h04);
        settle(2);
        chk_pin(int_pin, 1'b1);
        rdc(8'h6c, 32'h0104);
        pulse(8'h01);
        settle(2);
        chk_pin(int_pin, 1'b0);
        wrc(8'h7c, 32'h0200);
        settle(2);
        chk_pin(int_pin, 1'b1);
        rdc(8'h6c, 32'h0101);
        settle(2);
        chk_pin(int_pin, 1'b0);
        wrc(8'h7c, 32'h0);
        // An event in the very cycle of the clearing read survives it.
        fork
            rdc(8'h6c, 32'h0100);
            begin
                @(posedge clk);
                pulse(8'h80);
            end
        join
        rdc(8'h6c, 32'h0180);
        // One diagnostic run for every result code.
        for (int c = 0; c < 4; c++) begin
            wrc(8'h74, 32'h8000);
            #1 chk_pin(diag_start, 1'b1);
            rdc(8'h74, prev | 32'h8000);
            diag <= pcd_diag_t'({1'b1, 2'(c), 9'h155 + 9'(c)});
            @(posedge clk);
            diag <= '0;
            #1 chk_pin(diag_start, 1'b0);
            prev = {17'h0, 2'(c), 4'h0, 9'h155 + 9'(c)};
            rdc(8'h74, prev);
        end
        diag <= pcd_diag_t'({1'b1, 2'h1, 9'h0aa});
        @(posedge clk);
        diag <= '0;
        rdc(8'h74, prev);
        // Every indicator mode with link up, no activity, fast line.
        line <= pcd_line_t'(6'b111101);
        for (int m = 0; m < 4; m++) begin
            wrc(8'h78, 32'(m) << 14);
            settle(2);
            chk_reg(32'(led_mode), 32'(m));
            chk_pin(ind_first, m < 2);
            chk_pin(ind_second, m == 0);
            rdc(8'h78, (32'(m) << 14) | 32'h3800);
        end
        line <= pcd_line_t'(6'b000111);
        rdc(8'h78, 32'hc000);
        wrc(8'h78, 32'h0);
        settle(2);
        chk_pin(ind_first, 1'b0);
        // Unmapped place answers with an error.
        pcd_mac_model_inst.wr(8'h40, 32'hffff, r);
        chk_reg({30'h0, r}, {30'h0, `PCD_RESP_SLVERR});
        pcd_mac_model_inst.rd(8'h40, d, r);
        chk_reg({r, d[29:0]}, {`PCD_RESP_SLVERR, 30'h0});
        // Second reset in mid-run clears the enables.
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        settle(1);
        chk_pin(int_pin, 1'b1);
        rdc(8'h6c, 32'h0);
        stop_test;
    end
endmodule
